// *** hw/efc_codec.sv ***
// Frame codec: receive parser, frame buffer and transmit framer
`timescale 1ns/1ps
`default_nettype none
module efc_codec (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [1:0] MODE_SEL,
  input wire logic RX_IN_VALID,
  input wire logic [7:0] RX_IN_BYTE,
  output logic RX_IN_READY,
  output logic RX_OUT_VALID,
  output var efc_pkg::efc_beat_t RX_OUT,
  input wire logic RX_OUT_READY,
  input wire logic TX_REQ_VALID,
  input wire logic [15:0] TX_REQ_LEN,
  output logic TX_REQ_READY,
  input wire logic TX_DATA_VALID,
  input wire logic [7:0] TX_DATA,
  output logic TX_DATA_READY,
  output logic TX_OUT_VALID,
  output logic [7:0] TX_OUT_BYTE,
  input wire logic TX_OUT_READY
);
  // ************************************************************
  // Declarations
  // ************************************************************
  logic escm;
  efc_pkg::efc_rx_st_t rx_st_r, rx_st_nxt;
  logic [15:0] len_r, len_nxt, idx_r, idx_nxt;
  logic [7:0] sum_r, sum_nxt;
  logic esc_r, esc_nxt;
  logic [7:0] rx_val, len_lo;
  logic rx_take, rx_plain, wr_en;
  logic err_ev;
  logic [7:0] err_code;
  efc_pkg::efc_beat_t ro_r, ro_nxt;
  logic ro_vld_r, ro_vld_nxt;
  logic [7:0] rxbuf [efc_pkg::RXBUF_DEPTH];
  logic stat_req_r, stat_req_nxt, take_stat;
  logic [7:0] reason_r, reason_nxt;
  efc_pkg::efc_tx_st_t tx_st_r, tx_st_nxt;
  logic [15:0] tlen_r, tlen_nxt, tcnt_r, tcnt_nxt;
  logic [7:0] tsum_r, tsum_nxt;
  logic tstat_r, tstat_nxt;
  logic tx_vld_r, tx_vld_nxt;
  logic [7:0] tx_out_r, tx_out_nxt;
  logic pend_r, pend_nxt;
  logic [7:0] pend_byte_r, pend_byte_nxt;
  logic tx_ld, raw_ok, need;
  logic [7:0] raw;
  logic fifo_vld, fifo_rd;
  logic [7:0] fifo_data;

  // Mode 2 escapes, anything else is plain framing; mode must be held
  // stable across a frame, a change mid-frame corrupts that frame
  assign escm = MODE_SEL == efc_pkg::MODE_ESC;
  assign RX_IN_READY = rx_st_r != efc_pkg::RX_DRAIN;
  assign rx_take = RX_IN_VALID && RX_IN_READY;
  assign rx_val = esc_r ? RX_IN_BYTE ^ efc_pkg::ESC_XOR : RX_IN_BYTE;
  assign rx_plain = rx_take && !(escm && (RX_IN_BYTE == efc_pkg::DELIM
                    || RX_IN_BYTE == efc_pkg::ESC));
  assign len_lo = rx_val;
  assign RX_OUT_VALID = ro_vld_r;
  assign RX_OUT = ro_r;

  // ************************************************************
  // Receive parser
  // ************************************************************
  always_comb begin
    rx_st_nxt = rx_st_r;
    len_nxt = len_r;
    idx_nxt = idx_r;
    sum_nxt = sum_r;
    esc_nxt = esc_r;
    wr_en = 1'b0;
    err_ev = 1'b0;
    err_code = efc_pkg::ERR_CSUM;
    ro_nxt = ro_r;
    ro_vld_nxt = ro_vld_r && !RX_OUT_READY;
    if (rx_take) begin
      if (escm && RX_IN_BYTE == efc_pkg::DELIM) begin
        // Raw delimiter restarts; partial frame is thrown away
        if (rx_st_r != efc_pkg::RX_HUNT) begin
          err_ev = 1'b1;
          err_code = efc_pkg::ERR_ABORT;
        end
        rx_st_nxt = efc_pkg::RX_LENH;
        len_nxt = efc_pkg::LEN_ZERO;
        idx_nxt = efc_pkg::LEN_ZERO;
        sum_nxt = efc_pkg::BYTE_ZERO;
        esc_nxt = 1'b0;
      end else if (escm && RX_IN_BYTE == efc_pkg::ESC
                   && rx_st_r != efc_pkg::RX_HUNT) begin
        esc_nxt = 1'b1;
      end else begin
        esc_nxt = 1'b0;
        case (rx_st_r)
          efc_pkg::RX_HUNT: begin
            if (RX_IN_BYTE == efc_pkg::DELIM) begin
              rx_st_nxt = efc_pkg::RX_LENH;
              len_nxt = efc_pkg::LEN_ZERO;
              idx_nxt = efc_pkg::LEN_ZERO;
              sum_nxt = efc_pkg::BYTE_ZERO;
            end
            // Anything else before a delimiter falls away
          end
          efc_pkg::RX_LENH: begin
            len_nxt = {rx_val, efc_pkg::BYTE_ZERO};
            rx_st_nxt = efc_pkg::RX_LENL;
          end
          efc_pkg::RX_LENL: begin
            len_nxt = {len_r[15:8], len_lo};
            // A frame must carry a type byte and fit the buffer
            if ({len_r[15:8], len_lo} == efc_pkg::LEN_ZERO
                || {len_r[15:8], len_lo} > efc_pkg::RXBUF_MAX) begin
              err_ev = 1'b1;
              err_code = efc_pkg::ERR_LEN;
              rx_st_nxt = efc_pkg::RX_HUNT;
            end else begin
              rx_st_nxt = efc_pkg::RX_DATA;
            end
          end
          efc_pkg::RX_DATA: begin
            // Only decoded bytes are counted and summed
            wr_en = 1'b1;
            sum_nxt = sum_r + rx_val;
            idx_nxt = idx_r + efc_pkg::LEN_ONE;
            if (idx_r + efc_pkg::LEN_ONE == len_r) begin
              rx_st_nxt = efc_pkg::RX_CSUM;
            end
          end
          efc_pkg::RX_CSUM: begin
            idx_nxt = efc_pkg::LEN_ZERO;
            if (8'(sum_r + rx_val) == efc_pkg::CSUM_GOOD) begin
              rx_st_nxt = efc_pkg::RX_DRAIN;
            end else begin
              err_ev = 1'b1;
              err_code = efc_pkg::ERR_CSUM;
              rx_st_nxt = efc_pkg::RX_HUNT;
            end
          end
          default: begin
            rx_st_nxt = efc_pkg::RX_HUNT;
          end
        endcase
      end
    end
    // Only a checked frame leaves the buffer
    if (rx_st_r == efc_pkg::RX_DRAIN && (!ro_vld_r || RX_OUT_READY)) begin
      if (idx_r == len_r) begin
        rx_st_nxt = efc_pkg::RX_HUNT;
        sum_nxt = efc_pkg::BYTE_ZERO;
      end else begin
        ro_vld_nxt = 1'b1;
        ro_nxt.data = rxbuf[idx_r[7:0]];
        ro_nxt.last = idx_r + efc_pkg::LEN_ONE == len_r;
        idx_nxt = idx_r + efc_pkg::LEN_ONE;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rx_st_r <= efc_pkg::RX_HUNT;
      len_r <= efc_pkg::LEN_ZERO;
      idx_r <= efc_pkg::LEN_ZERO;
      sum_r <= efc_pkg::BYTE_ZERO;
      esc_r <= 1'b0;
      ro_r <= '0;
      ro_vld_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      len_r <= len_nxt;
      idx_r <= idx_nxt;
      sum_r <= sum_nxt;
      esc_r <= esc_nxt;
      ro_r <= ro_nxt;
      ro_vld_r <= ro_vld_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (wr_en) begin
      rxbuf[idx_r[7:0]] <= rx_val;
    end
  end

  // ************************************************************
  // Status request; a new error wins over the framer taking it
  // ************************************************************
  always_comb begin
    stat_req_nxt = err_ev || (stat_req_r && !take_stat);
    reason_nxt = err_ev ? err_code : reason_r;
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      stat_req_r <= 1'b0;
      reason_r <= efc_pkg::BYTE_ZERO;
    end else begin
      stat_req_r <= stat_req_nxt;
      reason_r <= reason_nxt;
    end
  end

  // ************************************************************
  // Transmit frame data buffer
  // ************************************************************
  efc_fifo #(
    .WIDTH(efc_pkg::BYTE_W),
    .DEPTH(efc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .rst_b(RST_B),
    .in_valid(TX_DATA_VALID),
    .in_ready(TX_DATA_READY),
    .in_data(TX_DATA),
    .out_valid(fifo_vld),
    .out_ready(fifo_rd),
    .out_data(fifo_data)
  );

  // ************************************************************
  // Transmit framer
  // ************************************************************
  assign TX_REQ_READY = tx_st_r == efc_pkg::TX_IDLE && !stat_req_r;
  assign TX_OUT_VALID = tx_vld_r;
  assign TX_OUT_BYTE = tx_out_r;
  assign tx_ld = !tx_vld_r || TX_OUT_READY;

  always_comb begin
    raw = efc_pkg::DELIM;
    case (tx_st_r)
      efc_pkg::TX_LENH: raw = tlen_r[15:8];
      efc_pkg::TX_LENL: raw = tlen_r[7:0];
      efc_pkg::TX_DATA: begin
        if (tstat_r) begin
          raw = tcnt_r == efc_pkg::STAT_LEN ? efc_pkg::STAT_TYPE : reason_r;
        end else begin
          raw = fifo_data;
        end
      end
      efc_pkg::TX_CSUM: raw = efc_pkg::CSUM_GOOD - tsum_r;
      default: raw = efc_pkg::DELIM;
    endcase
    raw_ok = tx_st_r != efc_pkg::TX_IDLE
             && (tx_st_r != efc_pkg::TX_DATA || tstat_r || fifo_vld);
    // The delimiter itself is never escaped
    need = escm && tx_st_r != efc_pkg::TX_DELIM
           && efc_pkg::efc_needs_esc(raw);
  end

  always_comb begin
    tx_st_nxt = tx_st_r;
    tlen_nxt = tlen_r;
    tcnt_nxt = tcnt_r;
    tsum_nxt = tsum_r;
    tstat_nxt = tstat_r;
    tx_vld_nxt = tx_vld_r && !TX_OUT_READY;
    tx_out_nxt = tx_out_r;
    pend_nxt = pend_r;
    pend_byte_nxt = pend_byte_r;
    fifo_rd = 1'b0;
    take_stat = 1'b0;
    if (tx_st_r == efc_pkg::TX_IDLE) begin
      if (stat_req_r) begin
        take_stat = 1'b1;
        tstat_nxt = 1'b1;
        tlen_nxt = efc_pkg::STAT_LEN;
        tcnt_nxt = efc_pkg::STAT_LEN;
        tsum_nxt = efc_pkg::BYTE_ZERO;
        tx_st_nxt = efc_pkg::TX_DELIM;
      end else if (TX_REQ_VALID) begin
        tstat_nxt = 1'b0;
        tlen_nxt = TX_REQ_LEN;
        tcnt_nxt = TX_REQ_LEN;
        tsum_nxt = efc_pkg::BYTE_ZERO;
        tx_st_nxt = efc_pkg::TX_DELIM;
      end
    end else if (tx_ld && pend_r) begin
      tx_vld_nxt = 1'b1;
      tx_out_nxt = pend_byte_r;
      pend_nxt = 1'b0;
    end else if (tx_ld && raw_ok) begin
      tx_vld_nxt = 1'b1;
      if (need) begin
        tx_out_nxt = efc_pkg::ESC;
        pend_nxt = 1'b1;
        pend_byte_nxt = raw ^ efc_pkg::ESC_XOR;
      end else begin
        tx_out_nxt = raw;
      end
      case (tx_st_r)
        efc_pkg::TX_DELIM: tx_st_nxt = efc_pkg::TX_LENH;
        efc_pkg::TX_LENH: tx_st_nxt = efc_pkg::TX_LENL;
        efc_pkg::TX_LENL: begin
          tx_st_nxt = tcnt_r == efc_pkg::LEN_ZERO ? efc_pkg::TX_CSUM
                      : efc_pkg::TX_DATA;
        end
        efc_pkg::TX_DATA: begin
          tsum_nxt = tsum_r + raw;
          tcnt_nxt = tcnt_r - efc_pkg::LEN_ONE;
          fifo_rd = !tstat_r;
          if (tcnt_r == efc_pkg::LEN_ONE) begin
            tx_st_nxt = efc_pkg::TX_CSUM;
          end
        end
        default: tx_st_nxt = efc_pkg::TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      tx_st_r <= efc_pkg::TX_IDLE;
      tlen_r <= efc_pkg::LEN_ZERO;
      tcnt_r <= efc_pkg::LEN_ZERO;
      tsum_r <= efc_pkg::BYTE_ZERO;
      tstat_r <= 1'b0;
      tx_vld_r <= 1'b0;
      tx_out_r <= efc_pkg::BYTE_ZERO;
      pend_r <= 1'b0;
      pend_byte_r <= efc_pkg::BYTE_ZERO;
    end else begin
      tx_st_r <= tx_st_nxt;
      tlen_r <= tlen_nxt;
      tcnt_r <= tcnt_nxt;
      tsum_r <= tsum_nxt;
      tstat_r <= tstat_nxt;
      tx_vld_r <= tx_vld_nxt;
      tx_out_r <= tx_out_nxt;
      pend_r <= pend_nxt;
      pend_byte_r <= pend_byte_nxt;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  hunt_drop_a: assert property (
    rx_st_r == efc_pkg::RX_HUNT && rx_take
    && RX_IN_BYTE != efc_pkg::DELIM |=> rx_st_r == efc_pkg::RX_HUNT)
    else $error("byte before delimiter was not dropped");
  esc_abort_a: assert property (
    escm && rx_take && RX_IN_BYTE == efc_pkg::DELIM
    |=> rx_st_r == efc_pkg::RX_LENH && idx_r == efc_pkg::LEN_ZERO
        && sum_r == efc_pkg::BYTE_ZERO)
    else $error("raw delimiter did not restart the frame");
  len_msb_a: assert property (
    rx_st_r == efc_pkg::RX_LENH && rx_plain
    |=> len_r[15:8] == $past(rx_val) && rx_st_r == efc_pkg::RX_LENL)
    else $error("length high byte not taken first");
  csum_good_a: assert property (
    rx_st_r == efc_pkg::RX_CSUM && rx_plain
    && 8'(sum_r + rx_val) == efc_pkg::CSUM_GOOD
    |=> rx_st_r == efc_pkg::RX_DRAIN ##1 RX_OUT_VALID)
    else $error("good frame not released");
  bad_frame_a: assert property (
    rx_st_r == efc_pkg::RX_CSUM && rx_plain
    && 8'(sum_r + rx_val) != efc_pkg::CSUM_GOOD
    |=> rx_st_r == efc_pkg::RX_HUNT && stat_req_r
        && reason_r == efc_pkg::ERR_CSUM)
    else $error("bad frame not reported");
  no_flow_a: assert property (
    TX_OUT_VALID && escm |-> TX_OUT_BYTE != efc_pkg::XON
    && TX_OUT_BYTE != efc_pkg::XOFF)
    else $error("flow control value sent unescaped");
  esc_pair_a: assert property (
    TX_OUT_VALID && TX_OUT_READY && escm
    && TX_OUT_BYTE == efc_pkg::ESC
    |=> TX_OUT_VALID
        && efc_pkg::efc_needs_esc(TX_OUT_BYTE ^ efc_pkg::ESC_XOR))
    else $error("escape not followed by transformed byte");
  tx_csum_a: assert property (
    tx_ld && !pend_r && tx_st_r == efc_pkg::TX_CSUM && !need
    |=> TX_OUT_BYTE == efc_pkg::CSUM_GOOD - $past(tsum_r)
        && tx_st_r == efc_pkg::TX_IDLE)
    else $error("wrong transmit checksum");
  delim_a: assert property (
    tx_ld && !pend_r && tx_st_r == efc_pkg::TX_DELIM
    |=> TX_OUT_VALID && TX_OUT_BYTE == efc_pkg::DELIM && !pend_r)
    else $error("frame did not open with delimiter");
  plain_a: assert property (
    !escm && tx_ld && !pend_r |=> !pend_r)
    else $error("escape inserted in plain mode");

  good_c: cover property (rx_st_r == efc_pkg::RX_DRAIN
    && RX_OUT_VALID && RX_OUT_READY && RX_OUT.last);
  bad_c: cover property (err_ev && err_code == efc_pkg::ERR_CSUM);
  esc_c: cover property (pend_r && TX_OUT_VALID);
  stat_c: cover property (tstat_r && tx_st_r == efc_pkg::TX_CSUM);
endmodule
`default_nettype wire

// *** include/efc_pkg.sv ***
// Constants and types shared by the escaped frame codec
// Summary of operation
// - Mode setting 2 selects escaped framing; other settings use plain framing
// - Every frame starts with delimiter 0x7E; receiver finds frames by it
// - In escaped mode a raw 0x7E aborts the frame and starts a new one
// - Escaped mode sends 0x7D then the byte XORed with 0x20; code holds an escaped checksum's XORed byte until the next frame starts
// - Bytes escaped are exactly 0x7E, 0x7D, 0x11 and 0x13
// - Device escapes on transmit and removes escapes on receive first
// - Length counts unescaped frame-data bytes only, never inserted escapes
// - Checksum uses unescaped values, same for escaped and plain frames
// - Two length bytes follow the delimiter, high byte first, checksum excluded
// - First frame-data byte is the frame type identifier
// - Multi-byte values are sent most significant byte first
// - Transmit checksum is 0xFF minus low 8 bits of frame-data sum
// - Received frame valid only when data plus checksum sums to 0xFF
// - Frames with a bad checksum are invalid and their data is dropped
// - Bytes arriving before a start delimiter are silently dropped
// - Badly received or failing frames trigger a status frame with reason
// - Mode setting 1 is plain framing; escaped framing only on serial port
package efc_pkg;
  localparam logic [1:0] MODE_ESC = 2'h2;
  localparam logic [1:0] MODE_RAW = 2'h1;
  localparam logic [7:0] DELIM = 8'h7e;
  localparam logic [7:0] ESC = 8'h7d;
  localparam logic [7:0] ESC_XOR = 8'h20;
  localparam logic [7:0] XON = 8'h11;
  localparam logic [7:0] XOFF = 8'h13;
  localparam logic [7:0] CSUM_GOOD = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] LEN_ZERO = 16'h0000;
  localparam logic [15:0] LEN_ONE = 16'h0001;
  localparam int RXBUF_DEPTH = 256;
  localparam logic [15:0] RXBUF_MAX = 16'h0100;
  localparam int FIFO_DEPTH = 8;
  localparam int BYTE_W = 8;
  localparam logic [15:0] STAT_LEN = 16'h0002;
  // Status frame type; value is arbitrary
  localparam logic [7:0] STAT_TYPE = 8'hf0;
  localparam logic [7:0] ERR_CSUM = 8'h01;
  localparam logic [7:0] ERR_ABORT = 8'h02;
  localparam logic [7:0] ERR_LEN = 8'h03;

  typedef enum logic [5:0] {
    RX_HUNT = 6'h01, RX_LENH = 6'h02, RX_LENL = 6'h04,
    RX_DATA = 6'h08, RX_CSUM = 6'h10, RX_DRAIN = 6'h20
  } efc_rx_st_t;

  typedef enum logic [5:0] {
    TX_IDLE = 6'h01, TX_DELIM = 6'h02, TX_LENH = 6'h04,
    TX_LENL = 6'h08, TX_DATA = 6'h10, TX_CSUM = 6'h20
  } efc_tx_st_t;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } efc_beat_t;

  function automatic logic efc_needs_esc(input logic [7:0] b);
    return (b == DELIM) || (b == ESC) || (b == XON) || (b == XOFF);
  endfunction
endpackage

// *** hw/efc_fifo.sv ***
// Small valid/ready FIFO for transmit frame data
`timescale 1ns/1ps
`default_nettype none
module efc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // DEPTH must be a power of two; pointers carry one wrap bit
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;

  assign in_ready = (wp_r - rp_r) != FULL_CNT;
  assign out_valid = wp_r != rp_r;
  assign out_data = mem[rp_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

// *** verification/efc_host_model.sv ***
// Host controller model: sends framed bytes and sinks encoded output
`timescale 1ns/1ps
`default_nettype none
module efc_host_model (
  input wire logic clk,
  input wire logic stall,
  input wire logic rx_in_ready,
  output logic rx_in_valid,
  output logic [7:0] rx_in_byte,
  input wire logic tx_out_valid,
  input wire logic [7:0] tx_out_byte,
  output logic tx_out_ready
);
  logic [8:0] txq[$];
  logic [1:0] cyc;

  initial begin
    rx_in_valid = 1'b0;
    rx_in_byte = 8'h00;
    tx_out_ready = 1'b1;
    cyc = 2'h0;
  end

  // ****************************************
  // Output sink
  // ****************************************
  // Slow mode takes one byte in four so the framer must hold its output
  always @(negedge clk) begin
    cyc = cyc + 2'h1;
    tx_out_ready = !stall || (cyc == 2'h0);
  end

  always @(posedge clk) begin
    if (tx_out_valid && tx_out_ready) begin
      txq.push_back({1'b0, tx_out_byte});
    end
  end

  // ****************************************
  // Byte sender
  // ****************************************
  task automatic send_byte(input logic [7:0] b);
    @(negedge clk);
    rx_in_valid = 1'b1;
    rx_in_byte = b;
    while (!rx_in_ready) @(negedge clk);
    @(posedge clk);
  endtask

  // Released line shows the inverse so a stale byte cannot pass
  task automatic rx_end();
    @(negedge clk);
    rx_in_valid = 1'b0;
    rx_in_byte = ~rx_in_byte;
  endtask

  task automatic send_enc(input logic [7:0] b, input logic esc);
    if (esc && (b == 8'h7e || b == 8'h7d || b == 8'h11 || b == 8'h13)) begin
      send_byte(8'h7d);
      send_byte(b ^ 8'h20);
    end else begin
      send_byte(b);
    end
  endtask

  // Flip breaks the checksum on purpose when non-zero
  task automatic send_frame(input logic esc, input logic [7:0] d[$],
                            input logic [7:0] flip);
    logic [7:0] sum;
    logic [15:0] len;
    sum = 8'h00;
    len = 16'(d.size());
    send_byte(8'h7e);
    send_enc(len[15:8], esc);
    send_enc(len[7:0], esc);
    foreach (d[i]) begin
      sum = sum + d[i];
      send_enc(d[i], esc);
    end
    send_enc((8'hff - sum) ^ flip, esc);
    rx_end();
  endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking testbench for the escaped frame codec
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rst_b, stall, rx_in_valid, rx_in_ready, rx_out_valid;
  logic rx_out_ready, tx_req_valid, tx_req_ready, tx_data_valid;
  logic tx_data_ready, tx_out_valid, tx_out_ready;
  logic [1:0] mode_sel;
  logic [7:0] rx_in_byte, tx_data, tx_out_byte;
  logic [15:0] tx_req_len;
  efc_pkg::efc_beat_t rx_out;
  logic [8:0] rxq[$];
  logic [7:0] no_bytes[$];
  logic [8:0] no_beats[$];
  int fail_count, check_count;

  efc_codec dut (.CLK(clk), .RST_B(rst_b), .MODE_SEL(mode_sel),
    .RX_IN_VALID(rx_in_valid), .RX_IN_BYTE(rx_in_byte),
    .RX_IN_READY(rx_in_ready), .RX_OUT_VALID(rx_out_valid),
    .RX_OUT(rx_out), .RX_OUT_READY(rx_out_ready),
    .TX_REQ_VALID(tx_req_valid), .TX_REQ_LEN(tx_req_len),
    .TX_REQ_READY(tx_req_ready), .TX_DATA_VALID(tx_data_valid),
    .TX_DATA(tx_data), .TX_DATA_READY(tx_data_ready),
    .TX_OUT_VALID(tx_out_valid), .TX_OUT_BYTE(tx_out_byte),
    .TX_OUT_READY(tx_out_ready));

  efc_host_model host (.clk(clk), .stall(stall), .rx_in_ready(rx_in_ready),
    .rx_in_valid(rx_in_valid), .rx_in_byte(rx_in_byte),
    .tx_out_valid(tx_out_valid), .tx_out_byte(tx_out_byte),
    .tx_out_ready(tx_out_ready));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (rx_out_valid && rx_out_ready) begin
      rxq.push_back(rx_out);
    end
  end

  // Stalled consumer takes every other byte so the output must hold
  always @(negedge clk) begin
    rx_out_ready = !stall || (rx_out_valid && !rx_out_ready);
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cmp_q(input string nm, input logic [8:0] got[$],
                       input logic [8:0] exp[$]);
    check({nm, " count"}, 16'(got.size()), 16'(exp.size()));
    foreach (exp[i]) begin
      if (i < got.size()) check(nm, 16'(got[i]), 16'(exp[i]));
    end
  endtask

  // Bounded wait for traffic, then a quiet spell to expose extra bytes
  task automatic await(input int ntx, input int nrx);
    int k;
    k = 0;
    while ((host.txq.size() < ntx || rxq.size() < nrx) && k < 400) begin
      @(negedge clk);
      k++;
    end
    repeat (12) @(negedge clk);
  endtask

  task automatic clear_q();
    host.txq.delete();
    rxq.delete();
  endtask

  task automatic push_seq(input logic [7:0] d[$]);
    foreach (d[i]) begin
      @(negedge clk);
      tx_data_valid = 1'b1;
      tx_data = d[i];
      while (!tx_data_ready) @(negedge clk);
      @(posedge clk);
    end
    @(negedge clk);
    tx_data_valid = 1'b0;
    tx_data = ~tx_data;
  endtask

  task automatic send_req(input logic [15:0] n);
    @(negedge clk);
    tx_req_valid = 1'b1;
    tx_req_len = n;
    while (!tx_req_ready) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    tx_req_valid = 1'b0;
    tx_req_len = ~n;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    check("rx ready", 16'(rx_in_ready), 16'h0001);
    check("rx valid", 16'(rx_out_valid), 16'h0000);
    check("tx valid", 16'(tx_out_valid), 16'h0000);
    check("req ready", 16'(tx_req_ready), 16'h0001);
    host.send_byte(8'h7e);
    host.send_byte(8'h00);
    host.send_byte(8'h03);
    host.send_byte(8'haa);
    host.rx_end();
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    host.send_frame(1'b0, '{8'h5a}, 8'h00);
    await(0, 1);
    cmp_q("rx after reset", rxq, '{9'h15a});
    clear_q();
    $display("test reset done");
  endtask

  // Mode 0 is plain too, so 0x7e inside the frame is data
  task automatic t_rx_plain();
    mode_sel = 2'h0;
    stall = 1'b1;
    host.send_byte(8'h55);
    host.send_byte(8'h7d);
    host.rx_end();
    host.send_frame(1'b0, '{8'haa, 8'h55, 8'h7e}, 8'h00);
    await(0, 3);
    cmp_q("rx plain", rxq, '{9'h0aa, 9'h055, 9'h17e});
    cmp_q("no status", host.txq, no_beats);
    stall = 1'b0;
    clear_q();
    $display("test rx plain done");
  endtask

  task automatic t_rx_esc();
    mode_sel = 2'h2;
    host.send_byte(8'h7e);
    host.send_byte(8'h00);
    host.send_byte(8'h05);
    host.send_byte(8'h01);
    host.send_frame(1'b1, '{8'h13, 8'h7e, 8'h7d, 8'h11}, 8'h00);
    await(6, 4);
    cmp_q("rx esc", rxq, '{9'h013, 9'h07e, 9'h07d, 9'h111});
    cmp_q("abort status", host.txq,
      '{9'h07e, 9'h000, 9'h002, 9'h0f0, 9'h002, 9'h00d});
    clear_q();
    $display("test rx escaped done");
  endtask

  task automatic t_rx_bad();
    mode_sel = 2'h1;
    host.send_frame(1'b0, '{8'haa}, 8'h01);
    await(6, 0);
    cmp_q("csum status", host.txq,
      '{9'h07e, 9'h000, 9'h002, 9'h0f0, 9'h001, 9'h00e});
    clear_q();
    host.send_frame(1'b0, no_bytes, 8'h00);
    await(6, 0);
    cmp_q("len status", host.txq,
      '{9'h07e, 9'h000, 9'h002, 9'h0f0, 9'h003, 9'h00c});
    cmp_q("bad data", rxq, no_beats);
    clear_q();
    $display("test rx bad done");
  endtask

  // Fill the buffer before the request so it must refuse, then drain slowly
  task automatic t_tx_fifo();
    stall = 1'b1;
    push_seq('{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08});
    check("fifo full", 16'(tx_data_ready), 16'h0000);
    send_req(16'h0008);
    await(12, 0);
    cmp_q("tx plain", host.txq, '{9'h07e, 9'h000, 9'h008, 9'h001, 9'h002,
      9'h003, 9'h004, 9'h005, 9'h006, 9'h007, 9'h008, 9'h0db});
    check("fifo empty", 16'(tx_data_ready), 16'h0001);
    stall = 1'b0;
    clear_q();
    $display("test tx fifo done");
  endtask

  task automatic t_tx_esc();
    mode_sel = 2'h2;
    push_seq('{8'h7e, 8'h7d, 8'h11, 8'h13});
    send_req(16'h0004);
    await(12, 0);
    cmp_q("tx esc", host.txq, '{9'h07e, 9'h000, 9'h004, 9'h07d, 9'h05e,
      9'h07d, 9'h05d, 9'h07d, 9'h031, 9'h07d, 9'h033, 9'h0e0});
    clear_q();
    $display("test tx escaped done");
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    rst_b = 1'b0;
    stall = 1'b0;
    mode_sel = 2'h1;
    tx_req_valid = 1'b0;
    tx_req_len = 16'h0000;
    tx_data_valid = 1'b0;
    tx_data = 8'h00;
    fail_count = 0;
    check_count = 0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    t_reset();
    t_rx_plain();
    t_rx_esc();
    t_rx_bad();
    t_tx_fifo();
    t_tx_esc();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
